//--- verilog/gpd_ports.sv
// port D direction, port E and port F pin logic behind an apb register slave.
// assumes pins are synchronous-ish levels, peripherals supply their drive values.
//
// Operation
// RULE1 - port D direction one drives pin, zero leaves input; reset clears all
// RULE2 - port D data read gives latch if direction one, else pin level
// RULE3 - data latches always accept writes; input pins read unaffected
// RULE4 - software should load latch before turning a pin to output
// RULE5 - direction registers read back last written or reset value
// RULE6 - port E data read gives latch if direction one, else pin level
// RULE7 - port E direction one drives pin, zero leaves input; reset clears all
// RULE8 - spi off: E7..E5 plain io; else spi clock, mosi, miso
// RULE9 - E4 plain io unless spi slave or master with fault detect
// RULE10 - peripheral-owned E pin ignores direction for drive, not for reads
// RULE11 - E3, E2 carry timer A channels 1, 0 when selected
// RULE12 - sci off: E1, E0 plain io; on: sci owns receive and transmit
// RULE13 - seven port F latches, untouched by reset
// RULE14 - F3..F0 carry timer A channels 5..2 when selected
// RULE15 - F5, F4 carry timer B channels 1, 0 when selected
// RULE16 - timer-owned F pin ignores direction for drive, not for reads
// RULE17 - port F data read gives latch if direction one, else pin level
// RULE18 - reset clears port F direction bits, all pins input
// RULE19 - pin levels pass a two-stage synchroniser before bus reads
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
module gpd_ports (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire gpd_pkg::gpd_apb_req_t apbReq,
  output gpd_pkg::gpd_apb_rsp_t apbRsp,
  input wire gpd_pkg::gpd_pins_t pinIn,
  output gpd_pkg::gpd_pins_t pinOut,
  output gpd_pkg::gpd_pins_t pinOe,
  input wire gpd_pkg::gpd_periph_t periphIn,
  output gpd_pkg::gpd_pins_t pinSync
);

  typedef struct packed {
    logic [7:0] dirD;
    logic [7:0] dirE;
    logic [6:0] dirF;
    logic [3:0] ctl;
    logic [11:0] elsA;
    logic [3:0] elsB;
    gpd_pkg::gpd_apb_rsp_t rsp;
    gpd_pkg::gpd_pins_t out;
    gpd_pkg::gpd_pins_t oe;
  } gpd_state_t;

  // data latches keep no reset, so they live apart from the reset state
  typedef struct packed {
    logic [7:0] d;
    logic [7:0] e;
    logic [6:0] f;
  } gpd_latch_t;

  gpd_state_t st_r;
  gpd_state_t st_nxt;
  gpd_latch_t lat_r;
  gpd_latch_t lat_nxt;
  logic rstSyncN;
  gpd_pkg::gpd_pins_t pinS;
  logic [5:0] idx;
  logic setupPh;
  logic wrAcc;
  logic known;
  logic [31:0] rdVal;
  logic spiEn;
  logic spiMst;
  logic sciEn;

  gpd_sync2 #(.WIDTH(1)) u_rst_sync (
    .clk(ref_clk),
    .rstN(rst_n),
    .din(1'b1),
    .dout(rstSyncN)
  );

  gpd_sync2 #(.WIDTH($bits(gpd_pkg::gpd_pins_t))) u_pin_sync (
    .clk(ref_clk),
    .rstN(rstSyncN),
    .din(pinIn),
    .dout(pinS) // [RULE19]
  );

  always_comb begin
    st_nxt = st_r;
    lat_nxt = lat_r;
    idx = apbReq.paddr[7:2];
    setupPh = apbReq.psel & !apbReq.penable;
    wrAcc = apbReq.psel & apbReq.penable & st_r.rsp.pready & apbReq.pwrite;
    spiEn = st_r.ctl[gpd_pkg::CTL_SPI_ENABLE];
    spiMst = st_r.ctl[gpd_pkg::CTL_SPI_MASTER];
    sciEn = st_r.ctl[gpd_pkg::CTL_SCI_ENABLE];
    known = 1'b1;
    rdVal = 32'h0000_0000;
    // reads choose latch or synchronised pin by direction, owned or not
    unique case (idx)
      gpd_pkg::IDX_PORTD_DATA: rdVal[7:0] = (st_r.dirD & lat_r.d) | (~st_r.dirD & pinS.d); // [RULE2]
      gpd_pkg::IDX_PORTE_DATA: rdVal[7:0] = (st_r.dirE & lat_r.e) | (~st_r.dirE & pinS.e); // [RULE6] [RULE10]
      gpd_pkg::IDX_PORTF_DATA: rdVal[6:0] = (st_r.dirF & lat_r.f) | (~st_r.dirF & pinS.f); // [RULE17] [RULE16]
      gpd_pkg::IDX_PORTD_DIR: rdVal[7:0] = st_r.dirD; // [RULE5]
      gpd_pkg::IDX_PORTE_DIR: rdVal[7:0] = st_r.dirE; // [RULE5]
      gpd_pkg::IDX_PORTF_DIR: rdVal[6:0] = st_r.dirF; // [RULE5]
      gpd_pkg::IDX_PERIPH_CTL: rdVal[3:0] = st_r.ctl;
      gpd_pkg::IDX_TIMER_A_MODULE_ELS: rdVal[11:0] = st_r.elsA;
      gpd_pkg::IDX_TIMER_B_MODULE_ELS: rdVal[3:0] = st_r.elsB;
      default: known = 1'b0;
    endcase
    // zero-wait slave: setup cycle loads the answer, access cycle shows it
    st_nxt.rsp.pready = setupPh;
    st_nxt.rsp.pslverr = setupPh & !known;
    if (setupPh) begin
      st_nxt.rsp.prdata = rdVal;
    end
    // unmapped writes are dropped; a write lands at the access edge only
    if (wrAcc && known && apbReq.pstrb[0]) begin
      unique case (idx)
        gpd_pkg::IDX_PORTD_DATA: lat_nxt.d = apbReq.pwdata[7:0]; // [RULE3]
        gpd_pkg::IDX_PORTE_DATA: lat_nxt.e = apbReq.pwdata[7:0]; // [RULE3]
        gpd_pkg::IDX_PORTF_DATA: lat_nxt.f = apbReq.pwdata[6:0]; // [RULE3] [RULE13]
        gpd_pkg::IDX_PORTD_DIR: st_nxt.dirD = apbReq.pwdata[7:0]; // [RULE5]
        gpd_pkg::IDX_PORTE_DIR: st_nxt.dirE = apbReq.pwdata[7:0]; // [RULE5]
        gpd_pkg::IDX_PORTF_DIR: st_nxt.dirF = apbReq.pwdata[6:0]; // [RULE5]
        gpd_pkg::IDX_PERIPH_CTL: st_nxt.ctl = apbReq.pwdata[3:0];
        gpd_pkg::IDX_TIMER_A_MODULE_ELS: st_nxt.elsA[7:0] = apbReq.pwdata[7:0];
        gpd_pkg::IDX_TIMER_B_MODULE_ELS: st_nxt.elsB = apbReq.pwdata[3:0];
        default: st_nxt.rsp.pslverr = 1'b0;
      endcase
    end
    if (wrAcc && idx == gpd_pkg::IDX_TIMER_A_MODULE_ELS && apbReq.pstrb[1]) begin
      st_nxt.elsA[11:8] = apbReq.pwdata[11:8];
    end
    // port D: plain io only
    st_nxt.out.d = lat_r.d;
    st_nxt.oe.d = st_r.dirD; // [RULE1]
    // port E: latch and direction unless a peripheral owns the pin
    st_nxt.out.e = lat_r.e;
    st_nxt.oe.e = st_r.dirE; // [RULE7]
    if (spiEn) begin
      // master drives clock and mosi, slave drives miso [RULE8] [RULE10]
      st_nxt.out.e[gpd_pkg::PE_SPI_CLK] = periphIn.spiClk;
      st_nxt.oe.e[gpd_pkg::PE_SPI_CLK] = spiMst;
      st_nxt.out.e[gpd_pkg::PE_SPI_MOSI] = periphIn.spiMosi;
      st_nxt.oe.e[gpd_pkg::PE_SPI_MOSI] = spiMst;
      st_nxt.out.e[gpd_pkg::PE_SPI_MISO] = periphIn.spiMiso;
      st_nxt.oe.e[gpd_pkg::PE_SPI_MISO] = !spiMst;
      // select pin is an input unless master without fault detect [RULE9]
      if (!spiMst || st_r.ctl[gpd_pkg::CTL_MODE_FAULT]) begin
        st_nxt.oe.e[gpd_pkg::PE_SPI_SEL] = 1'b0;
      end
    end
    for (int k = 0; k < 2; k++) begin
      if (gpd_pkg::chanSel(st_r.elsA[2*k +: 2])) begin
        st_nxt.out.e[gpd_pkg::PE_TIMER_A_MODULE_CH0 + k] = periphIn.timAOut[k]; // [RULE11]
        st_nxt.oe.e[gpd_pkg::PE_TIMER_A_MODULE_CH0 + k] = periphIn.timAOe[k]; // [RULE10]
      end
    end
    if (sciEn) begin
      st_nxt.oe.e[gpd_pkg::PE_SCI_RX] = 1'b0; // [RULE12]
      st_nxt.out.e[gpd_pkg::PE_SCI_TX] = periphIn.sciTx;
      st_nxt.oe.e[gpd_pkg::PE_SCI_TX] = 1'b1; // [RULE12]
    end
    // port F: timer A channels 5..2 on bits 3..0, timer B on bits 5..4
    st_nxt.out.f = lat_r.f;
    st_nxt.oe.f = st_r.dirF;
    for (int k = 0; k < 4; k++) begin
      if (gpd_pkg::chanSel(st_r.elsA[2*(k+2) +: 2])) begin
        st_nxt.out.f[gpd_pkg::PF_TIMER_A_MODULE_CH2 + k] = periphIn.timAOut[k+2]; // [RULE14]
        st_nxt.oe.f[gpd_pkg::PF_TIMER_A_MODULE_CH2 + k] = periphIn.timAOe[k+2]; // [RULE16]
      end
    end
    for (int k = 0; k < 2; k++) begin
      if (gpd_pkg::chanSel(st_r.elsB[2*k +: 2])) begin
        st_nxt.out.f[gpd_pkg::PF_TIMER_B_MODULE_CH0 + k] = periphIn.timBOut[k]; // [RULE15]
        st_nxt.oe.f[gpd_pkg::PF_TIMER_B_MODULE_CH0 + k] = periphIn.timBOe[k]; // [RULE16]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      st_r <= '0;
      st_r.dirD <= gpd_pkg::DIR8_RST; // [RULE1]
      st_r.dirE <= gpd_pkg::DIR8_RST; // [RULE7]
      st_r.dirF <= gpd_pkg::DIR7_RST; // [RULE18]
      st_r.ctl <= gpd_pkg::CTL_RST;
      st_r.elsA <= gpd_pkg::ELSA_RST;
      st_r.elsB <= gpd_pkg::ELSB_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // no reset here: latch contents survive a chip reset
  always_ff @(posedge ref_clk) begin
    lat_r <= lat_nxt; // [RULE13]
  end

  assign apbRsp = st_r.rsp;
  assign pinOut = st_r.out;
  assign pinOe = st_r.oe;
  assign pinSync = pinS;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstSyncN);

  a_dird_drive: assert property (##1 pinOe.d == $past(st_r.dirD)) // [RULE1]
    else $error("port D enables do not follow direction");
  a_dir_reset: assert property ($rose(rstSyncN) |-> st_r.dirD == 8'h00 && st_r.dirE == 8'h00
    && st_r.dirF == 7'h00) // [RULE18]
    else $error("direction bits not clear after reset");
  a_portd_read: assert property (setupPh && idx == gpd_pkg::IDX_PORTD_DATA |=> apbRsp.pready
    && apbRsp.prdata[7:0] == (($past(st_r.dirD) & $past(lat_r.d))
    | (~$past(st_r.dirD) & $past(pinS.d)))) // [RULE2]
    else $error("port D read mux wrong");
  a_portf_read: assert property (setupPh && idx == gpd_pkg::IDX_PORTF_DATA |=>
    apbRsp.prdata[6:0] == (($past(st_r.dirF) & $past(lat_r.f))
    | (~$past(st_r.dirF) & $past(pinS.f))) && apbRsp.prdata[31:7] == 25'h0) // [RULE17]
    else $error("port F read mux wrong");
  a_latch_write: assert property (wrAcc && known && apbReq.pstrb[0]
    && idx == gpd_pkg::IDX_PORTE_DATA |=> lat_r.e == $past(apbReq.pwdata[7:0])) // [RULE3]
    else $error("port E latch missed a write");
  a_dir_readback: assert property (wrAcc && apbReq.pstrb[0] && idx == gpd_pkg::IDX_PORTE_DIR
    |=> st_r.dirE == $past(apbReq.pwdata[7:0])) // [RULE5]
    else $error("direction write not stored");
  a_porte_read: assert property (setupPh && idx == gpd_pkg::IDX_PORTE_DATA |=> // [RULE6]
    apbRsp.prdata[7:0] == (($past(st_r.dirE) & $past(lat_r.e))
    | (~$past(st_r.dirE) & $past(pinS.e))) && apbRsp.prdata[31:8] == 24'h0)
    else $error("port E read mux wrong");
  a_latch_dwrite: assert property (wrAcc && known && apbReq.pstrb[0] // [RULE3]
    && idx == gpd_pkg::IDX_PORTD_DATA |=> lat_r.d == $past(apbReq.pwdata[7:0]))
    else $error("port D latch missed a write");
  a_spi_master_own: assert property (spiEn && spiMst |=> pinOe.e[7] && pinOe.e[6] // [RULE8]
    && !pinOe.e[5] && pinOut.e[7] == $past(periphIn.spiClk))
    else $error("spi master pins not owned by spi");
  a_sel_plain_io: assert property (spiEn && spiMst && !st_r.ctl[gpd_pkg::CTL_MODE_FAULT] // [RULE9]
    |=> pinOe.e[4] == $past(st_r.dirE[4]))
    else $error("select pin not plain io as master");
  a_sci_off_io: assert property (!sciEn |=> pinOe.e[1:0] == $past(st_r.dirE[1:0])) // [RULE12]
    else $error("sci pins not plain io while sci off");
  a_timer_a_module_f_own: assert property (gpd_pkg::chanSel(st_r.elsA[5:4]) // [RULE14]
    |=> pinOut.f[0] == $past(periphIn.timAOut[2]) && pinOe.f[0] == $past(periphIn.timAOe[2]))
    else $error("timer A channel 2 not on F0");
  a_f6_plain_io: assert property (##1 pinOe.f[6] == $past(st_r.dirF[6])) // [RULE14]
    else $error("port F bit 6 not plain io");
  a_ready_pulse: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("pready held longer than one cycle");
  a_spi_off_io: assert property (!spiEn |=> pinOe.e[7:5] == $past(st_r.dirE[7:5])) // [RULE8]
    else $error("spi pins not plain io while spi off");
  a_ss_slave_in: assert property (spiEn && !spiMst |=> !pinOe.e[gpd_pkg::PE_SPI_SEL]) // [RULE9]
    else $error("select pin driven as spi slave");
  a_sci_tx_own: assert property (sciEn |=> pinOe.e[gpd_pkg::PE_SCI_TX]
    && pinOut.e[gpd_pkg::PE_SCI_TX] == $past(periphIn.sciTx)
    && !pinOe.e[gpd_pkg::PE_SCI_RX]) // [RULE12]
    else $error("sci pins not owned by sci");
  a_timer_a_module_e_own: assert property (gpd_pkg::chanSel(st_r.elsA[3:2])
    |=> pinOe.e[3] == $past(periphIn.timAOe[1])) // [RULE11]
    else $error("timer A channel 1 not on E3");
  a_timer_b_module_f_own: assert property (gpd_pkg::chanSel(st_r.elsB[1:0]) // [RULE15]
    |=> pinOut.f[4] == $past(periphIn.timBOut[0]) && pinOe.f[4] == $past(periphIn.timBOe[0]))
    else $error("timer B channel 0 not on F4");
  a_unmapped_err: assert property (setupPh && !known |=> apbRsp.pready && apbRsp.pslverr)
    else $error("unmapped access not flagged");

  c_portd_read: cover property (setupPh && idx == gpd_pkg::IDX_PORTD_DATA ##1 apbRsp.pready);
  c_spi_slave: cover property (spiEn && !spiMst);
  c_timf_own: cover property (gpd_pkg::chanSel(st_r.elsA[5:4]) && st_r.dirF[0]);
  c_sci_on: cover property (sciEn && st_r.dirE[0]);
  c_spi_master: cover property (spiEn && spiMst && !st_r.ctl[gpd_pkg::CTL_MODE_FAULT]);

endmodule

//--- shared/gpd_pkg.sv
// package for the port D/E/F pin block: register indices, field positions,
// reset values and the structs that carry the bus, the pins and peripheral signals.
// assumes an apb master with 32-bit data and 8-bit byte addresses.
package gpd_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_PORTD_DATA = 6'h03;
  localparam logic [5:0] IDX_PORTE_DATA = 6'h08;
  localparam logic [5:0] IDX_PORTF_DATA = 6'h09;
  localparam logic [5:0] IDX_PORTD_DIR = 6'h0C;
  localparam logic [5:0] IDX_PORTE_DIR = 6'h0D;
  localparam logic [5:0] IDX_PORTF_DIR = 6'h0E;
  localparam logic [5:0] IDX_PERIPH_CTL = 6'h10;
  localparam logic [5:0] IDX_TIMER_A_MODULE_ELS = 6'h11;
  localparam logic [5:0] IDX_TIMER_B_MODULE_ELS = 6'h12;

  // peripheral control field positions
  localparam int CTL_SPI_ENABLE = 0;
  localparam int CTL_SPI_MASTER = 1;
  localparam int CTL_MODE_FAULT = 2;
  localparam int CTL_SCI_ENABLE = 3;

  // port E pin positions of shared functions
  localparam int PE_SPI_CLK = 7;
  localparam int PE_SPI_MOSI = 6;
  localparam int PE_SPI_MISO = 5;
  localparam int PE_SPI_SEL = 4;
  localparam int PE_TIMER_A_MODULE_CH0 = 2;
  localparam int PE_SCI_RX = 1;
  localparam int PE_SCI_TX = 0;
  // port F: bits 3..0 carry timer A channels 5..2, bits 5..4 timer B channels 1..0
  localparam int PF_TIMER_A_MODULE_CH2 = 0;
  localparam int PF_TIMER_B_MODULE_CH0 = 4;

  // values after reset
  localparam logic [7:0] DIR8_RST = 8'h00;
  localparam logic [6:0] DIR7_RST = 7'h00;
  localparam logic [3:0] CTL_RST = 4'h0;
  localparam logic [11:0] ELSA_RST = 12'h000;
  localparam logic [3:0] ELSB_RST = 4'h0;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } gpd_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } gpd_apb_rsp_t;

  typedef struct packed {
    logic [7:0] d;
    logic [7:0] e;
    logic [6:0] f;
  } gpd_pins_t;

  // drive values coming from the shared peripherals
  typedef struct packed {
    logic spiClk;
    logic spiMosi;
    logic spiMiso;
    logic sciTx;
    logic [5:0] timAOut;
    logic [5:0] timAOe;
    logic [1:0] timBOut;
    logic [1:0] timBOe;
  } gpd_periph_t;

  // a timer channel owns its pin whenever its edge/level field is non-zero
  function automatic logic chanSel(input logic [1:0] els);
    return |els;
  endfunction

endpackage

//--- verilog/gpd_sync2.sv
// two-stage synchroniser for a vector of levels.
// assumes rstN is already synchronous to clk where data, not reset, is passed.
`timescale 1ns/10ps
module gpd_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } gpd_sync_st_t;

  gpd_sync_st_t st_r;
  gpd_sync_st_t st_nxt;

  // stage1 feeds stage2 only, nothing else looks at it
  always_comb begin
    st_nxt = st_r;
    st_nxt.stage1 = din;
    st_nxt.stage2 = st_r.stage1;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.stage2;

endmodule

//--- tb/gpd_pin_model.sv
// board circuitry on the port D/E/F pins: resolves each pin from both drivers.
// assumes the bench supplies the level that the board drives on undriven pins.
`timescale 1ns/10ps
module gpd_pin_model (
  input wire gpd_pkg::gpd_pins_t pinOut,
  input wire gpd_pkg::gpd_pins_t pinOe,
  input wire gpd_pkg::gpd_pins_t boardDrv,
  output gpd_pkg::gpd_pins_t pinLevel
);
  // the device wins where it drives; elsewhere the board level shows, never a stale value
  assign pinLevel = gpd_pkg::gpd_pins_t'((pinOe & pinOut) | (~pinOe & boardDrv));
endmodule

//--- tb/gpio_ports_d_e_f_tb.sv
// self-checking bench for the port D/E/F pin block: random register and pin traffic.
// assumes the pin model stands for the board and peripheral drive values come from here.
`timescale 1ns/10ps
module gpio_ports_d_e_f_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  gpd_pkg::gpd_apb_req_t req = '0;
  gpd_pkg::gpd_apb_rsp_t rsp;
  gpd_pkg::gpd_pins_t pinOut;
  gpd_pkg::gpd_pins_t pinOe;
  gpd_pkg::gpd_pins_t pinLevel;
  gpd_pkg::gpd_pins_t pinSyncV;
  gpd_pkg::gpd_pins_t board = '0;
  gpd_pkg::gpd_periph_t periph = '0;
  int nMismatch = 0;
  int nChecks = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;
  logic [7:0] dD, lD, dE, lE;
  logic [6:0] dF, lF;
  logic [3:0] ctl;
  logic [11:0] ela;
  logic [3:0] elb;
  logic [15:0] ee;
  logic [13:0] ef;
  logic [7:0] wE;
  logic [6:0] wF;

  always #5 ref_clk = ~ref_clk;

  gpd_ports i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .apbReq(req), .apbRsp(rsp),
    .pinIn(pinLevel), .pinOut(pinOut), .pinOe(pinOe), .periphIn(periph), .pinSync(pinSyncV));
  gpd_pin_model i_pins (.pinOut(pinOut), .pinOe(pinOe), .boardDrv(board), .pinLevel(pinLevel));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // run is about 830 cycles; the ceiling leaves ample room
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      nMismatch++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; waits for pready under a bound, never a fixed count
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    int n;
    @(posedge ref_clk);
    req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:{idx, 2'b00}, pwdata:wd, pstrb:4'hF};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) nMismatch++;
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // ctl bits: 0 spi on, 1 spi master, 2 mode fault, 3 sci on
  function automatic logic [15:0] expE(input logic [3:0] c, input logic [3:0] el,
      input logic [7:0] dir, input logic [7:0] lat, input gpd_pkg::gpd_periph_t p);
    logic [7:0] oe;
    logic [7:0] o;
    oe = dir;
    o = lat;
    if (c[0]) begin
      oe[7] = c[1];
      oe[6] = c[1];
      oe[5] = !c[1];
      o[7:5] = {p.spiClk, p.spiMosi, p.spiMiso};
      if (!c[1] || c[2]) oe[4] = 1'b0;
    end
    for (int k = 0; k < 2; k++) if (|el[2*k +: 2]) begin
      oe[2+k] = p.timAOe[k];
      o[2+k] = p.timAOut[k];
    end
    if (c[3]) begin
      oe[1:0] = 2'b01;
      o[0] = p.sciTx;
    end
    return {oe, o};
  endfunction

  function automatic logic [13:0] expF(input logic [7:0] ea, input logic [3:0] eb,
      input logic [6:0] dir, input logic [6:0] lat, input gpd_pkg::gpd_periph_t p);
    logic [6:0] oe;
    logic [6:0] o;
    oe = dir;
    o = lat;
    for (int k = 0; k < 4; k++) if (|ea[2*k +: 2]) begin
      oe[k] = p.timAOe[k+2];
      o[k] = p.timAOut[k+2];
    end
    for (int k = 0; k < 2; k++) if (|eb[2*k +: 2]) begin
      oe[4+k] = p.timBOe[k];
      o[4+k] = p.timBOut[k];
    end
    return {oe, o};
  endfunction

  initial begin
    void'($urandom(40698));
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    for (int r = 12; r <= 14; r++) begin
      apb(1'b0, r[5:0], 32'h0);
      chk(rd, 32'h0);
    end
    chk({9'h0, pinOe}, 32'h0);
    $display("test reset done");
    // every control combination once, with random fields, latches and pin levels
    for (int i = 0; i < 16; i++) begin
      ctl = i[3:0];
      ela = 12'($urandom);
      elb = 4'($urandom);
      {dD, lD, dE, lE, dF, lF} = 46'({$urandom, $urandom});
      periph <= gpd_pkg::gpd_periph_t'($urandom);
      board <= gpd_pkg::gpd_pins_t'($urandom);
      // latches before directions, so no pin glitches
      apb(1'b1, gpd_pkg::IDX_PORTD_DATA, {24'h0, lD});
      apb(1'b1, gpd_pkg::IDX_PORTE_DATA, {24'h0, lE});
      apb(1'b1, gpd_pkg::IDX_PORTF_DATA, {25'h0, lF});
      apb(1'b1, gpd_pkg::IDX_PORTD_DIR, {24'h0, dD});
      apb(1'b1, gpd_pkg::IDX_PORTE_DIR, {24'h0, dE});
      apb(1'b1, gpd_pkg::IDX_PORTF_DIR, {25'h0, dF});
      apb(1'b1, gpd_pkg::IDX_PERIPH_CTL, {28'h0, ctl});
      apb(1'b1, gpd_pkg::IDX_TIMER_A_MODULE_ELS, {20'h0, ela});
      apb(1'b1, gpd_pkg::IDX_TIMER_B_MODULE_ELS, {28'h0, elb});
      repeat (4) @(posedge ref_clk);
      ee = expE(ctl, ela[3:0], dE, lE, periph);
      ef = expF(ela[11:4], elb, dF, lF, periph);
      wE = (ee[15:8] & ee[7:0]) | (~ee[15:8] & board.e);
      wF = (ef[13:7] & ef[6:0]) | (~ef[13:7] & board.f);
      chk({9'h0, pinSyncV}, {9'h0, pinLevel});
      chk(pinOe.d, dD);
      chk(pinOut.d & dD, lD & dD);
      chk(pinOe.e, ee[15:8]);
      chk(pinOut.e & ee[15:8], ee[7:0] & ee[15:8]);
      chk(pinOe.f, ef[13:7]);
      chk(pinOut.f & ef[13:7], ef[6:0] & ef[13:7]);
      apb(1'b0, gpd_pkg::IDX_PORTD_DATA, 32'h0);
      chk(rd, {24'h0, (dD & lD) | (~dD & board.d)});
      apb(1'b0, gpd_pkg::IDX_PORTE_DATA, 32'h0);
      chk(rd, {24'h0, (dE & lE) | (~dE & wE)});
      apb(1'b0, gpd_pkg::IDX_PORTF_DATA, 32'h0);
      chk(rd, {25'h0, (dF & lF) | (~dF & wF)});
      apb(1'b0, gpd_pkg::IDX_PORTD_DIR, 32'h0);
      chk(rd, {24'h0, dD});
      apb(1'b0, gpd_pkg::IDX_PORTE_DIR, 32'h0);
      chk(rd, {24'h0, dE});
      apb(1'b0, gpd_pkg::IDX_PORTF_DIR, 32'h0);
      chk(rd, {25'h0, dF});
    end
    $display("test random traffic done");
    apb(1'b1, 6'h3F, 32'hFFFFFFFF);
    apb(1'b0, 6'h3F, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("test unmapped done");
    // a second reset must clear directions but keep the port F latches
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk({9'h0, pinOe}, 32'h0);
    apb(1'b1, gpd_pkg::IDX_PORTF_DIR, 32'h7F);
    apb(1'b0, gpd_pkg::IDX_PORTF_DATA, 32'h0);
    chk(rd, {25'h0, lF});
    $display("test latch retention done");
    complete_run();
  end
endmodule
